// ===== nic_host_model.sv
// apb host model that drives the register window
`default_nettype none
module nic_host_model
    import nic_pages_pkg::*;
(
    input  wire logic        pclk,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [11:0] paddr,
    output var  logic [31:0] pwdata,
    output var  logic [3:0]  pstrb,
    input  wire logic        pready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
    end
    // gap gives idle cycles so the host can be prompt or slow
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
                        input int gap, output logic ok);
        int n;
        n = 0;
        repeat (gap) @(posedge pclk);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 50);
        ok = pready;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines show the inverse so stale values never look valid
        pwrite <= ~wr;
        paddr <= ~a;
        pwdata <= ~{24'h000000, d};
        pstrb <= 4'h0;
    endtask
endmodule
`default_nettype wire

// ===== nic_pages_monitor.sv
// port checker for the nic register page front end
`default_nettype none
module nic_pages_monitor
    import nic_pages_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq,
    input wire logic        link_enable
);
    logic wr_setup;
    logic cmd_wr;
    // command sits at offset 0 of every page, so no page term is needed
    assign wr_setup = psel && !penable && pwrite && pstrb[0];
    assign cmd_wr   = wr_setup && paddr == 12'h000;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_stop_cmd_halts: assert property (cmd_wr && pwdata[1:0] == 2'b01
        |-> ##[1:2] !link_enable)
        else $error("stop command left link on");
    chk_start_cmd_runs: assert property (cmd_wr && pwdata[1:0] == 2'b10
        |-> ##[1:2] link_enable)
        else $error("start command left link off");
    chk_link_cause: assert property ($changed(link_enable)
        |-> $past(cmd_wr) || $past(cmd_wr, 2))
        else $error("link changed without command");
    // dma completion moves irq two cycles after its command; depth three covers it
    chk_irq_cause: assert property ($changed(irq)
        |-> $past(wr_setup) || $past(wr_setup, 2) || $past(wr_setup, 3))
        else $error("irq changed without write");
    chk_read_byte_wide: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("read data above byte lane");
    chk_refusal_silent: assert property (pready |-> !pslverr)
        else $error("error response given");
    chk_rdata_hold: assert property ($changed(prdata) |-> pready)
        else $error("read data changed outside answer");
    cover property (cmd_wr && pwdata[1:0] == 2'b10);
    cover property (irq ##1 !irq);
    cover property (pready && !pwrite ##2 pready && pwrite);
endmodule
bind nic_register_pages nic_pages_monitor nic_pages_monitor_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link_enable(link_enable));
`default_nettype wire

// ===== nic_pages_pkg.sv
// package of constants and carrier types for the nic register page front end
`default_nettype none
package nic_pages_pkg;
    localparam int   byte_width        = 8;
    localparam logic [11:0] addr_mask  = 12'h03C;
    // page-relative register indexes; byte address is index times four
    localparam logic [3:0] off_command      = 4'h0;
    localparam logic [3:0] off_ring_start   = 4'h1;
    localparam logic [3:0] off_ring_stop    = 4'h2;
    localparam logic [3:0] off_xmit_start   = 4'h4;
    localparam logic [3:0] off_int_status   = 4'h7;
    localparam logic [3:0] off_current_rx   = 4'h7;
    localparam logic [3:0] off_station0     = 4'h1;
    localparam logic [3:0] off_station5     = 4'h6;
    localparam logic [3:0] off_hash0        = 4'h8;
    localparam logic [3:0] off_rx_config    = 4'hC;
    localparam logic [3:0] off_tx_config    = 4'hD;
    localparam logic [3:0] off_data_config  = 4'hE;
    localparam logic [3:0] off_int_mask     = 4'hF;
    localparam logic [3:0] off_serial_ctrl  = 4'h1;
    localparam logic [3:0] off_boot_page    = 4'h2;
    localparam logic [3:0] off_jumper       = 4'h3;
    localparam logic [3:0] off_irq_io       = 4'h4;
    localparam logic [3:0] off_medium_boot  = 4'h5;
    localparam logic [3:0] off_led_power    = 4'h6;
    localparam logic [3:0] off_card_select  = 4'h8;
    localparam logic [3:0] off_clock_halt   = 4'h9;
    localparam logic [3:0] off_irq_levels   = 4'hB;
    // byte address of the event input register, outside the paged window
    localparam logic [11:0] addr_event_in   = 12'h040;
    // command field and status bit positions
    localparam int pos_page_hi   = 7;
    localparam int pos_page_lo   = 6;
    localparam int pos_dma_hi    = 5;
    localparam int pos_dma_lo    = 3;
    localparam int pos_xmit      = 2;
    localparam int pos_start     = 1;
    localparam int pos_stop      = 0;
    localparam int pos_rst_stat  = 7;
    localparam int pos_dma_done  = 6;
    // write masks of page 3 registers
    localparam logic [7:0] mask_irq_io      = 8'h80;
    localparam logic [7:0] mask_medium_boot = 8'hE0;
    localparam logic [7:0] mask_led_power   = 8'h06;
    localparam logic [7:0] mask_serial_wr   = 8'hCE;
    // reset values and the unlock mode
    localparam logic [7:0] reset_command    = 8'h21;
    localparam logic [7:0] reset_status     = 8'h80;
    localparam logic [7:0] reset_mask       = 8'h00;
    localparam logic [7:0] reset_data_cfg   = 8'h84;
    localparam logic [7:0] reset_tx_cfg     = 8'hE0;
    localparam logic [7:0] reset_zero       = 8'h00;
    localparam logic [1:0] serial_mode_cfg  = 2'h3;

    typedef enum logic [3:0] {
        page_zero  = 4'b0001,
        page_one   = 4'b0010,
        page_two   = 4'b0100,
        page_three = 4'b1000
    } page_type;

    typedef enum logic [3:0] {
        dma_idle   = 4'b0001,
        dma_read   = 4'b0010,
        dma_write  = 4'b0100,
        dma_send   = 4'b1000
    } dma_state_type;

    typedef struct packed {
        logic [7:0] command;
        logic [7:0] int_status;
        logic [7:0] int_mask;
        logic [7:0] ring_start;
        logic [7:0] ring_stop;
        logic [7:0] xmit_start;
        logic [7:0] rx_config;
        logic [7:0] tx_config;
        logic [7:0] data_config;
        logic [47:0] station;
        logic [7:0] current_rx;
        logic [63:0] hash;
        logic [7:0] serial_ctrl;
        logic [7:0] boot_page;
        logic [7:0] irq_io;
        logic [7:0] medium_boot;
        logic [7:0] led_power;
        logic [7:0] clock_halt;
        dma_state_type dma_state;
        logic [31:0] prdata;
        logic        pready;
        logic        irq;
        logic        link_enable;
    } state_type;
endpackage
`default_nettype wire

// ===== nic_register_pages.sv
// paged register front end of an ethernet controller behind an apb slave
//
// Contract
// - page select bits 7:6 choose pages 0-3
// - bits 5:3 decode remote dma commands
// - start bit written without stop clears the stop bit
// - stop bit halts traffic, set at reset
// - interrupt status readable at page 0 offset 7
// - status bits cleared by writing one
// - protected page 3 writes need mode bits 11
// - page 1 station, current page, hash bytes
// - remote dma finish sets dma complete bit
// - mask bits 6:0 enable matching status bits
`default_nettype none
module nic_register_pages
    import nic_pages_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output logic             pslverr,
    output var  logic        irq,
    output var  logic        link_enable
);
    state_type state;
    state_type next_state;

    page_type   page;
    logic       setup;
    logic       wr;
    logic       rd;
    logic       in_window;
    logic [3:0] idx;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic       unlocked;
    logic       dma_finish;

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (val & mask);
    endfunction

    function automatic logic [7:0] pick(input logic [63:0] vec, input logic [2:0] sel);
        pick = vec[{sel, 3'h0} +: 8];
    endfunction

    // bus write lands in the setup cycle; pready follows one cycle later
    assign setup     = psel & ~penable & ~state.pready;
    assign in_window = (paddr & ~addr_mask) == 12'h000;
    assign idx       = paddr[5:2];
    assign wr        = setup & pwrite & pstrb[0];
    assign rd        = setup & ~pwrite;
    assign wbyte     = pwdata[7:0];
    assign pslverr   = 1'b0;
    assign unlocked  = state.serial_ctrl[7:6] == serial_mode_cfg;

    always_comb begin
        case (state.command[pos_page_hi:pos_page_lo])
            2'b00:   page = page_zero;
            2'b01:   page = page_one;
            2'b10:   page = page_two;
            default: page = page_three;
        endcase
    end

    // remote dma completes one cycle after it is begun; no data path here
    assign dma_finish = state.dma_state != dma_idle;

    always_comb begin
        rbyte = reset_zero;
        if (idx == off_command) begin
            rbyte = state.command;
        end else begin
            case (page)
                page_zero: begin
                    if (idx == off_int_status) begin
                        rbyte = state.int_status;
                    end
                end
                page_one: begin
                    if (idx >= off_station0 && idx <= off_station5) begin
                        rbyte = pick({16'h0000, state.station}, 3'(idx - off_station0));
                    end else if (idx == off_current_rx) begin
                        rbyte = state.current_rx;
                    end else begin
                        rbyte = pick(state.hash, idx[2:0]);
                    end
                end
                page_two: begin
                    case (idx)
                        off_ring_start:  rbyte = state.ring_start;
                        off_ring_stop:   rbyte = state.ring_stop;
                        off_xmit_start:  rbyte = state.xmit_start;
                        off_rx_config:   rbyte = state.rx_config;
                        off_tx_config:   rbyte = state.tx_config;
                        off_data_config: rbyte = state.data_config;
                        off_int_mask:    rbyte = state.int_mask;
                        default:         rbyte = reset_zero;
                    endcase
                end
                page_three: begin
                    case (idx)
                        off_serial_ctrl: rbyte = state.serial_ctrl;
                        off_boot_page:   rbyte = state.boot_page;
                        off_jumper:      rbyte = reset_zero;
                        off_irq_io:      rbyte = state.irq_io;
                        off_medium_boot: rbyte = state.medium_boot;
                        off_led_power:   rbyte = state.led_power;
                        off_card_select: rbyte = reset_zero;
                        off_irq_levels:  rbyte = {7'h00, state.irq};
                        default:         rbyte = reset_zero;
                    endcase
                end
                default: rbyte = reset_zero;
            endcase
        end
    end

    always_comb begin
        logic [7:0] events;
        logic [7:0] clears;
        events     = 8'h00;
        clears     = 8'h00;
        next_state = state;
        next_state.pready = setup;
        if (rd) begin
            next_state.prdata = in_window ? {24'h000000, rbyte} : 32'h0000_0000;
        end
        if (setup && !pwrite) begin
            next_state.prdata = (paddr == addr_event_in)
                ? {24'h000000, state.int_status} : next_state.prdata;
        end
        // remote dma state: finishes one cycle after issue
        case (state.dma_state)
            dma_idle:  next_state.dma_state = dma_idle;
            dma_read:  next_state.dma_state = dma_idle;
            dma_write: next_state.dma_state = dma_idle;
            dma_send:  next_state.dma_state = dma_idle;
            default:   next_state.dma_state = dma_idle;
        endcase
        if (dma_finish) begin
            events[pos_dma_done] = 1'b1;
            next_state.command[pos_dma_hi:pos_dma_lo] = 3'b100;
        end
        // hardware events posted by a bus write to the event register
        if (wr && paddr == addr_event_in) begin
            events = events | wbyte;
        end
        if (wr && in_window) begin
            if (idx == off_command) begin
                next_state.command[pos_page_hi:pos_page_lo] = wbyte[7:6];
                next_state.command[pos_start] = wbyte[pos_start];
                if (wbyte[pos_dma_hi]) begin
                    next_state.command[pos_dma_hi:pos_dma_lo] = wbyte[5:3];
                    next_state.dma_state = dma_idle;
                end else if (wbyte[5:3] != 3'b000) begin
                    next_state.command[pos_dma_hi:pos_dma_lo] = wbyte[5:3];
                    case (wbyte[4:3])
                        2'b01:   next_state.dma_state = dma_read;
                        2'b10:   next_state.dma_state = dma_write;
                        default: next_state.dma_state = dma_send;
                    endcase
                end
                // code 000 is not allowed: the field keeps its old value
                if (wbyte[pos_start] && !wbyte[pos_stop]) begin
                    next_state.command[pos_stop] = 1'b0;
                    clears[pos_rst_stat] = 1'b1;
                end else if (wbyte[pos_stop]) begin
                    next_state.command[pos_stop] = 1'b1;
                    events[pos_rst_stat] = 1'b1;
                end
                // transmit bit self-clears; no transmitter is modelled
                next_state.command[pos_xmit] = 1'b0;
            end else begin
                case (page)
                    page_zero: begin
                        case (idx)
                            off_ring_start:  next_state.ring_start = wbyte;
                            off_ring_stop:   next_state.ring_stop = wbyte;
                            off_xmit_start:  next_state.xmit_start = wbyte;
                            off_int_status:  clears = clears | wbyte;
                            off_rx_config:   next_state.rx_config = wbyte;
                            off_tx_config:   next_state.tx_config = wbyte;
                            off_data_config: next_state.data_config = wbyte;
                            off_int_mask:    next_state.int_mask = wbyte;
                            default:         next_state.ring_start = state.ring_start;
                        endcase
                    end
                    page_one: begin
                        if (idx >= off_station0 && idx <= off_station5) begin
                            next_state.station[{3'(idx - off_station0), 3'h0} +: 8] =
                                wbyte;
                        end else if (idx == off_current_rx) begin
                            next_state.current_rx = wbyte;
                        end else begin
                            next_state.hash[{idx[2:0], 3'h0} +: 8] = wbyte;
                        end
                    end
                    page_three: begin
                        case (idx)
                            off_serial_ctrl: next_state.serial_ctrl =
                                merge(state.serial_ctrl, wbyte, mask_serial_wr);
                            off_boot_page:   next_state.boot_page = wbyte;
                            off_irq_io:      if (unlocked) begin
                                next_state.irq_io =
                                    merge(state.irq_io, wbyte, mask_irq_io);
                            end
                            off_medium_boot: if (unlocked) begin
                                next_state.medium_boot =
                                    merge(state.medium_boot, wbyte, mask_medium_boot);
                            end
                            off_led_power:   if (unlocked) begin
                                next_state.led_power =
                                    merge(state.led_power, wbyte, mask_led_power);
                            end
                            off_clock_halt:  next_state.clock_halt = wbyte;
                            default:         next_state.boot_page = state.boot_page;
                        endcase
                    end
                    default: next_state.command = next_state.command;
                endcase
            end
        end
        // a new event wins over a clear in the same cycle
        next_state.int_status = (state.int_status & ~clears) | events;
        // mask bit 7 has no cause behind it, so it never raises the line
        next_state.irq = |(next_state.int_status & {1'b0, next_state.int_mask[6:0]});
        next_state.link_enable = ~next_state.command[pos_stop];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state             <= '0;
            state.command     <= reset_command;
            state.int_status  <= reset_status;
            state.int_mask    <= reset_mask;
            state.data_config <= reset_data_cfg;
            state.tx_config   <= reset_tx_cfg;
            state.dma_state   <= dma_idle;
        end else begin
            state <= next_state;
        end
    end

    assign prdata      = state.prdata;
    assign pready      = state.pready;
    assign irq         = state.irq;
    assign link_enable = state.link_enable;
endmodule
`default_nettype wire

// ===== test_nic_register_pages.sv
// self-checking bench for the nic register page front end
`default_nettype none
module test_nic_register_pages
    import nic_pages_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, link_enable;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    int          errors, checks_done;
    logic [7:0]  expq [$];
    localparam logic [3:0] cfg_off [7] = '{off_ring_start, off_ring_stop, off_xmit_start,
        off_rx_config, off_tx_config, off_data_config, off_int_mask};
    localparam logic [3:0] p3_off [3] = '{off_irq_io, off_medium_boot, off_led_power};
    localparam logic [7:0] p3_msk [3] = '{mask_irq_io, mask_medium_boot, mask_led_power};
    nic_register_pages nic_register_pages_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .link_enable(link_enable));
    nic_host_model nic_host_model_i (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    function automatic logic [11:0] ra(input logic [3:0] o);
        return {6'h00, o, 2'b00};
    endfunction
    task automatic fail(input string m);
        $display("[ERR] %0t %s", $time, m);
        errors++;
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        logic ok;
        nic_host_model_i.xfer(w, a, d, $urandom_range(0, 2), ok);
        if (!ok) begin
            fail("bus answer timeout");
            tally_and_finish();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        expq.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic chk(input logic v, input logic e, input string m);
        checks_done++;
        if (v !== e) fail(m);
    endtask
    // watcher takes the oldest note for every answered read
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            checks_done++;
            if (expq.size() == 0) fail("read without note");
            else if (prdata !== {24'h000000, expq.pop_front()}) fail("read data mismatch");
        end
    end
    initial begin
        #800000;
        fail("run timeout");
        tally_and_finish();
    end
    initial begin
        logic [7:0] v [16];
        int i, j;
        presetn = 1'b0;
        errors = 0;
        checks_done = 0;
        void'($urandom(2));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(ra(off_command), reset_command);
        chk(link_enable, 1'b0, "link on out of reset");
        rd(ra(off_int_status), reset_status);
        wr(ra(off_int_status), 8'hFF);
        rd(ra(off_int_status), 8'h00);
        wr(ra(off_command), 8'h61);
        rd(ra(off_command), 8'h61);
        for (i = 1; i < 16; i++) v[i] = 8'($urandom);
        for (i = 1; i < 16; i++) wr(ra(4'(i)), v[i]);
        for (i = 1; i < 16; i++) rd(ra(4'(i)), v[i]);
        // page 2 returns the raw written byte, reserved bits included
        wr(ra(off_command), 8'h21);
        for (i = 0; i < 7; i++) wr(ra(cfg_off[i]), v[cfg_off[i]]);
        wr(ra(off_command), 8'hA1);
        for (i = 0; i < 7; i++) rd(ra(cfg_off[i]), v[cfg_off[i]]);
        wr(ra(off_command), 8'hE1);
        for (j = 0; j < 2; j++) begin
            wr(ra(off_serial_ctrl), j ? 8'hC0 : 8'h00);
            rd(ra(off_serial_ctrl), j ? 8'hC0 : 8'h00);
            for (i = 0; i < 3; i++) wr(ra(p3_off[i]), 8'hFF);
            for (i = 0; i < 3; i++) rd(ra(p3_off[i]), j ? p3_msk[i] : 8'h00);
        end
        wr(ra(off_command), 8'h21);
        wr(ra(off_int_status), 8'hFF);
        for (i = 0; i < 7; i++) begin
            wr(ra(off_int_mask), 8'(1 << i));
            wr(addr_event_in, 8'h7F & ~8'(1 << i));
            rd(ra(off_int_status), 8'h7F & ~8'(1 << i));
            chk(irq, 1'b0, "masked cause raised irq");
            wr(addr_event_in, 8'(1 << i));
            rd(ra(off_int_status), 8'h7F);
            chk(irq, 1'b1, "enabled cause gave no irq");
            wr(ra(off_int_status), 8'h00);
            rd(ra(off_int_status), 8'h7F);
            wr(ra(off_int_status), 8'(1 << i));
            rd(ra(off_int_status), 8'h7F & ~8'(1 << i));
            chk(irq, 1'b0, "cleared cause kept irq");
            wr(ra(off_int_status), 8'hFF);
        end
        wr(ra(off_int_mask), 8'h40);
        for (i = 1; i < 4; i++) begin
            wr(ra(off_command), {2'b00, 3'(i), 3'b010});
            rd(ra(off_command), 8'h22);
            rd(ra(off_int_status), 8'h40);
            chk(irq, 1'b1, "dma completion gave no irq");
            chk(link_enable, 1'b1, "start left link off");
            wr(ra(off_int_status), 8'h40);
        end
        // code 000 keeps the field and starts nothing; transmit bit self-clears
        wr(ra(off_command), 8'h06);
        rd(ra(off_command), 8'h22);
        rd(ra(off_int_status), 8'h00);
        wr(ra(off_command), 8'h23);
        rd(ra(off_command), 8'h23);
        chk(link_enable, 1'b0, "stop bit set but link on");
        wr(ra(off_command), 8'h21);
        rd(ra(off_command), 8'h21);
        rd(ra(off_int_status), 8'h80);
        rd(12'h080, 8'h00);
        wr(addr_event_in, 8'h40);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(ra(off_int_status), reset_status);
        chk(irq, 1'b0, "irq after reset");
        // let the watcher take the last answer before counting leftovers
        @(posedge pclk);
        checks_done++;
        if (expq.size() != 0) fail("read answer missing");
        tally_and_finish();
    end
endmodule
`default_nettype wire
